// [ext_conv_trigger_n_pkg.sv]
// Constants for the delayed-trigger sweep sequencer.
// Assumes one clock (the converter operation clock) and async low reset.
package ext_conv_trigger_n_pkg;
	localparam int RES_W       = 10;
	localparam int CH_N        = 8;
	localparam int CH_W        = 3;
	localparam int GRP_W       = 2;
	localparam int SEL_W       = 2;
	localparam int ST_W        = 2;
	localparam logic [1:0] ST_IDLE  = 2'h0;
	localparam logic [1:0] ST_WAIT  = 2'h1;
	localparam logic [1:0] ST_SWEEP = 2'h2;
	localparam logic [0:0] SYNC_RST = 1'h1;
	localparam logic [RES_W-1:0] RES_RST = 10'h000;

	typedef enum logic [2:0] {
		SQ_IDLE,
		SQ_CONV0,
		SQ_WAIT2,
		SQ_LAUNCH,
		SQ_CONVN
	} ext_conv_trigger_n_state_type;
endpackage

// [ext_conv_trigger_n_sync.sv]
// Two-flop synchroniser with falling-edge flag.
// Assumes an asynchronous pin input; resets to the idle-high level.
`timescale 1ns/1ps
module ext_conv_trigger_n_sync
	import ext_conv_trigger_n_pkg::*;
(
	// Clock and reset
	input  wire logic mclk_i,
	input  wire logic nrst_i,
	// Pin and edge
	input  wire logic pin_n_i,
	output logic      fall_o
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
	} ext_conv_trigger_n_sync_type;

	ext_conv_trigger_n_sync_type r_reg;
	ext_conv_trigger_n_sync_type r_next;

	always_comb begin
		r_next    = r_reg;
		r_next.s1 = pin_n_i;
		r_next.s2 = r_reg.s1;
		r_next.s3 = r_reg.s2;
	end

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			r_reg <= '{s1: SYNC_RST, s2: SYNC_RST, s3: SYNC_RST};
		end else begin
			r_reg <= r_next;
		end
	end

	assign fall_o = r_reg.s3 & ~r_reg.s2;
endmodule

// [ext_conv_trigger_n_result.sv]
// One channel result register, loaded when its conversion completes.
// Assumes result data and done strobe are on the operation clock.
`timescale 1ns/1ps
module ext_conv_trigger_n_result
	import ext_conv_trigger_n_pkg::*;
(
	// Clock and reset
	input  wire logic             mclk_i,
	input  wire logic             nrst_i,
	// Load
	input  wire logic             load_i,
	input  wire logic [RES_W-1:0] data_i,
	output logic      [RES_W-1:0] value_o
);
	typedef struct packed {
		logic [RES_W-1:0] value;
	} ext_conv_trigger_n_res_type;

	ext_conv_trigger_n_res_type r_reg;
	ext_conv_trigger_n_res_type r_next;

	always_comb begin
		r_next = r_reg;
		if (load_i) begin
			r_next.value = data_i;
		end
	end

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			r_reg <= '{value: RES_RST};
		end else begin
			r_reg <= r_next;
		end
	end

	assign value_o = r_reg.value;
endmodule

// [ext_conv_trigger_n_sweep.sv]
// Delayed trigger mode 1 sweep sequencer.
// Assumes an external analog core: it takes conv_start_o with channel and
// group, and answers conv_done_i with conv_data_i some cycles later.
`timescale 1ns/1ps
module ext_conv_trigger_n_sweep
	import ext_conv_trigger_n_pkg::*;
(
	// Clock and reset
	input  wire logic             mclk_i,
	input  wire logic             nrst_i,
	// Trigger pin
	input  wire logic             ext_conv_trigger_n_i,
	// Control bits
	input  wire logic             conversion_start_bit_i,
	input  wire logic             sweep_pin_select_hi_i,
	input  wire logic             sweep_pin_select_lo_i,
	input  wire logic             input_group_select_hi_i,
	input  wire logic             input_group_select_lo_i,
	// Analog core
	output logic                  conv_start_o,
	output logic      [CH_W-1:0]  conv_channel_o,
	output logic      [GRP_W-1:0] conv_group_o,
	output logic                  sample_ch1_o,
	input  wire logic             conv_done_i,
	input  wire logic [RES_W-1:0] conv_data_i,
	// Results and status
	output logic      [RES_W-1:0] result0_o,
	output logic      [RES_W-1:0] result1_o,
	output logic      [RES_W-1:0] result2_o,
	output logic      [RES_W-1:0] result3_o,
	output logic      [RES_W-1:0] result4_o,
	output logic      [RES_W-1:0] result5_o,
	output logic      [RES_W-1:0] result6_o,
	output logic      [RES_W-1:0] result7_o,
	output logic      [ST_W-1:0]  seq_status_o,
	output logic                  conv_irq_o
);
	typedef struct packed {
		ext_conv_trigger_n_state_type   state;
		logic [CH_W-1:0]   ch;
		logic [CH_W-1:0]   last;
		logic [GRP_W-1:0]  grp;
		logic              early;
		logic              start;
		logic              sample1;
		logic              irq;
		logic [ST_W-1:0]   status;
	} ext_conv_trigger_n_sweep_type;

	ext_conv_trigger_n_sweep_type r_reg;
	ext_conv_trigger_n_sweep_type r_next;
	logic            trig_fall;
	logic [CH_N-1:0] load;
	logic [RES_W-1:0] res [CH_N];

	//------------------------------------------------------------
	// Trigger edge
	//------------------------------------------------------------
	ext_conv_trigger_n_sync u_sync (
		.mclk_i  (mclk_i),
		.nrst_i  (nrst_i),
		.pin_n_i (ext_conv_trigger_n_i),
		.fall_o  (trig_fall)
	);

	//------------------------------------------------------------
	// Sequencer
	//------------------------------------------------------------
	always_comb begin
		r_next         = r_reg;
		r_next.start   = 1'b0;
		r_next.sample1 = 1'b0;
		r_next.irq     = 1'b0;
		unique case (r_reg.state)
			SQ_IDLE: begin
				if (trig_fall) begin
					r_next.state = SQ_CONV0;
					r_next.ch    = '0;
					r_next.start = 1'b1;
					r_next.early = 1'b0;
					// Set fixed for the whole sweep
					r_next.last  = {sweep_pin_select_hi_i,
						sweep_pin_select_lo_i, 1'b1};
					r_next.grp   = {input_group_select_hi_i,
						input_group_select_lo_i};
				end
			end
			SQ_CONV0: begin
				if (trig_fall && !r_reg.early) begin
					r_next.early   = 1'b1;
					r_next.sample1 = 1'b1;
				end
				if (conv_done_i) begin
					r_next.ch    = 3'h1;
					r_next.state = (r_reg.early || trig_fall) ?
						SQ_LAUNCH : SQ_WAIT2;
				end
			end
			SQ_WAIT2: begin
				if (trig_fall) begin
					r_next.state   = SQ_CONVN;
					r_next.start   = 1'b1;
					r_next.sample1 = 1'b1;
				end
			end
			SQ_LAUNCH: begin
				r_next.state = SQ_CONVN;
				r_next.start = 1'b1;
			end
			SQ_CONVN: begin
				// Trigger edges have no effect here
				if (conv_done_i) begin
					if (r_reg.ch == r_reg.last) begin
						r_next.state = SQ_IDLE;
						r_next.irq   = 1'b1;
					end else begin
						r_next.ch    = r_reg.ch + 3'h1;
						r_next.start = 1'b1;
					end
				end
			end
		endcase
		if (!conversion_start_bit_i && r_reg.state != SQ_IDLE) begin
			// Halt without interrupt
			r_next.state   = SQ_IDLE;
			r_next.start   = 1'b0;
			r_next.sample1 = 1'b0;
			r_next.irq     = 1'b0;
		end
		unique case (r_next.state)
			SQ_IDLE:  r_next.status = ST_IDLE;
			SQ_WAIT2: r_next.status = ST_WAIT;
			default:  r_next.status = ST_SWEEP;
		endcase
	end

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			r_reg <= '{state: SQ_IDLE, ch: '0, last: '0, grp: '0,
				early: 1'b0, start: 1'b0, sample1: 1'b0, irq: 1'b0,
				status: ST_IDLE};
		end else begin
			r_reg <= r_next;
		end
	end

	//------------------------------------------------------------
	// Result registers
	//------------------------------------------------------------
	always_comb begin
		load = '0;
		if (conv_done_i && (r_reg.state == SQ_CONV0 ||
				r_reg.state == SQ_CONVN) && conversion_start_bit_i) begin
			load[r_reg.ch] = 1'b1;
		end
	end

	for (genvar i = 0; i < CH_N; i++) begin : g_res
		ext_conv_trigger_n_result u_res (
			.mclk_i  (mclk_i),
			.nrst_i  (nrst_i),
			.load_i  (load[i]),
			.data_i  (conv_data_i),
			.value_o (res[i])
		);
	end

	assign result0_o      = res[0];
	assign result1_o      = res[1];
	assign result2_o      = res[2];
	assign result3_o      = res[3];
	assign result4_o      = res[4];
	assign result5_o      = res[5];
	assign result6_o      = res[6];
	assign result7_o      = res[7];
	assign conv_start_o   = r_reg.start;
	assign conv_channel_o = r_reg.ch;
	assign conv_group_o   = r_reg.grp;
	assign sample_ch1_o   = r_reg.sample1;
	assign seq_status_o   = r_reg.status;
	assign conv_irq_o     = r_reg.irq;
endmodule

// [ext_conv_trigger_n_sweep_props.sv]
// Port checker for the sweep sequencer.
// Assumes it is bound onto ext_conv_trigger_n_sweep.
`timescale 1ns/1ps
module ext_conv_trigger_n_sweep_props
	import ext_conv_trigger_n_pkg::*;
(
	input wire logic             mclk_i,
	input wire logic             nrst_i,
	input wire logic             conversion_start_bit_i,
	input wire logic             conv_start_o,
	input wire logic [CH_W-1:0]  conv_channel_o,
	input wire logic             sample_ch1_o,
	input wire logic             conv_done_i,
	input wire logic [RES_W-1:0] conv_data_i,
	input wire logic [RES_W-1:0] result0_o,
	input wire logic [ST_W-1:0]  seq_status_o,
	input wire logic             conv_irq_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!nrst_i);
	irq_on_done_a: assert property (conv_irq_o |->
		$past(conv_done_i) && seq_status_o == ST_IDLE) else $error("bad irq");
	first_ch_zero_a: assert property (conv_start_o &&
		$past(seq_status_o) == ST_IDLE |-> conv_channel_o == 3'h0)
		else $error("bad first channel");
	wait_no_start_a: assert property (seq_status_o == ST_WAIT |->
		!conv_start_o && !sample_ch1_o) else $error("start while waiting");
	wait_after_zero_a: assert property ($rose(seq_status_o == ST_WAIT)
		|-> $past(conv_done_i) && conv_channel_o == 3'h1)
		else $error("bad wait entry");
	next_channel_a: assert property (conv_start_o &&
		conv_channel_o > 3'h1 |-> $past(conv_done_i) &&
		conv_channel_o == $past(conv_channel_o) + 3'h1)
		else $error("bad channel step");
	sample_in_sweep_a: assert property (sample_ch1_o |->
		seq_status_o == ST_SWEEP) else $error("bad sample");
	zero_result_a: assert property (conv_done_i &&
		conv_channel_o == 3'h0 && seq_status_o != ST_IDLE &&
		conversion_start_bit_i |=> result0_o == $past(conv_data_i))
		else $error("bad result0");
	halt_stop_a: assert property (!conversion_start_bit_i &&
		seq_status_o != ST_IDLE |=> seq_status_o == ST_IDLE && !conv_irq_o)
		else $error("no halt");
	no_restart_a: assert property (conv_start_o &&
		conv_channel_o == 3'h0 |-> $past(seq_status_o) == ST_IDLE)
		else $error("sweep restarted");
endmodule
bind ext_conv_trigger_n_sweep ext_conv_trigger_n_sweep_props props_u (.*);

// [ext_conv_trigger_n_trig_src.sv]
// Trigger source model: each fire request gives one low pulse.
// Assumes fire requests are spaced at least three clocks apart.
`timescale 1ns/1ps
module ext_conv_trigger_n_trig_src (
	input  wire logic mclk_i,
	input  wire logic fire_i,
	output logic      trig_n_o
);
	logic [1:0] low_reg = 2'h0;
	// Low for two clocks, never shorter than one clock
	always @(posedge mclk_i)
		low_reg <= {low_reg[0], fire_i};
	assign trig_n_o = ~|low_reg;
endmodule

// [adc_delayed_trigger_sweep_tb.sv]
// Self-checking bench for the sweep sequencer.
// Assumes the analog core is modelled here with a latency set per sweep.
`timescale 1ns/1ps
`define CHK(n, e, s) begin samples_checked++; if ((e) !== (s)) begin \
	errors++; $display("Error %s exp %0h got %0h", n, e, s); end end
module adc_delayed_trigger_sweep_tb
	import ext_conv_trigger_n_pkg::*;
;
	logic mclk_i = 0, nrst_i = 0, fire = 0;
	logic conversion_start_bit_i = 1;
	logic sweep_pin_select_hi_i = 0, sweep_pin_select_lo_i = 0;
	logic input_group_select_hi_i = 0, input_group_select_lo_i = 0;
	logic conv_done_i = 0, ext_conv_trigger_n_i, conv_start_o;
	logic sample_ch1_o, conv_irq_o;
	logic [RES_W-1:0] conv_data_i = 0, result0_o, result1_o, result2_o;
	logic [RES_W-1:0] result3_o, result4_o, result5_o, result6_o, result7_o;
	logic [RES_W-1:0] res [CH_N], exp_res [CH_N];
	logic [CH_W-1:0]  conv_channel_o, ch_q;
	logic [GRP_W-1:0] conv_group_o, grp;
	logic [ST_W-1:0]  seq_status_o;
	int errors = 0, samples_checked = 0, seed = 40, busy = 0, lat = 3;
	int nst = 0, nsmp = 0, nirq = 0, nbad = 0, cyc = 0, k, last;
	int nst0 = 0, nsmp0 = 0, nirq0 = 0;
	assign res = '{result0_o, result1_o, result2_o, result3_o,
		result4_o, result5_o, result6_o, result7_o};
	always #50 mclk_i = ~mclk_i;
	ext_conv_trigger_n_sweep dut_u (.*);
	ext_conv_trigger_n_trig_src src_u (.mclk_i(mclk_i), .fire_i(fire),
		.trig_n_o(ext_conv_trigger_n_i));
	// Analog core model and event counters
	always @(posedge mclk_i) begin
		conv_done_i <= (busy == 1);
		if (busy == 1 && seq_status_o != ST_IDLE)
			exp_res[ch_q] <= conv_data_i;
		if (conv_start_o) begin
			busy <= lat;
			// Expected channel from the start count, not the design
			ch_q <= CH_W'(nst - nst0);
			nbad <= nbad + (conv_channel_o !== CH_W'(nst - nst0));
			conv_data_i <= RES_W'($random(seed));
			nst <= nst + 1;
		end else if (busy > 0)
			busy <= busy - 1;
		nsmp <= nsmp + sample_ch1_o;
		nirq <= nirq + conv_irq_o;
		cyc <= cyc + 1;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge mclk_i);
	endtask
	task automatic till(input logic [ST_W-1:0] s);
		for (k = 0; k < 200 && seq_status_o !== s; k++)
			tick(1);
		`CHK("status", s, seq_status_o)
	endtask
	task automatic pulse;
		@(posedge mclk_i) fire <= 1;
		@(posedge mclk_i) fire <= 0;
	endtask
	task automatic results;
		if (errors == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic run_all;
		repeat (12) @(posedge mclk_i);
		nrst_i <= 1;
		for (int i = 0; i < 8; i++) begin
			@(posedge mclk_i);
			grp = GRP_W'($random(seed));
			{sweep_pin_select_hi_i, sweep_pin_select_lo_i} <= 2'(i);
			{input_group_select_hi_i, input_group_select_lo_i} <= grp;
			lat <= (i < 4) ? 2 + i : 8;
			last = 2 * (i % 4) + 1;
			tick(1);
			nst0 = nst;
			nsmp0 = nsmp;
			nirq0 = nirq;
			pulse;
			if (i < 4) begin
				till(ST_WAIT);
				`CHK("held", 1, nst - nst0)
			end else
				till(ST_SWEEP);
			pulse;
			for (k = 0; k < 300 && nirq == nirq0; k++)
				tick(1);
			`CHK("irq", 1, nirq - nirq0)
			`CHK("starts", last + 1, nst - nst0)
			`CHK("sample", 1, nsmp - nsmp0)
			`CHK("group", grp, conv_group_o)
			for (int c = 0; c <= last; c++)
				`CHK("result", exp_res[c], res[c])
			`CHK("idle", ST_IDLE, seq_status_o)
			`CHK("order", 0, nbad)
		end
		nst0 = nst;
		nirq0 = nirq;
		pulse;
		till(ST_SWEEP);
		@(posedge mclk_i) conversion_start_bit_i <= 0;
		// Long enough for the in-flight conversion to finish
		tick(20);
		`CHK("halt", ST_IDLE, seq_status_o)
		`CHK("no irq", 0, nirq - nirq0)
		`CHK("halt result", exp_res[0], res[0])
		`CHK("halt starts", 1, nst - nst0)
	endtask
	initial begin
		fork
			run_all;
			begin
				wait (cyc >= 20000);
				errors++;
			end
		join_any
		results;
	end
endmodule
